// >>> hdl/serial_fmt_pkg.sv
/*
  Constants, types and helpers for the serial format control block.
  Assumes one system clock; mode settings come from same-clock logic.
*/
// Function
// - Bit 3 of the format register picks conversion order for transmit and receive.
// - Order bit 0: transmit LSB first, assemble received bits LSB first.
// - Order bit 1: transmit MSB first, store received bits MSB first.
// - The order bit only matters with 8-bit characters.
// - With 7-bit characters both paths are always LSB first.
// - Bit 2 of the format register selects data level inversion on the line.
// - Inversion never touches parity; parity is made and checked at normal level.
// - Invert bit 0: data go out and are stored unmodified.
package serial_fmt_pkg;
  localparam int DATA_W = 8;
  localparam logic [7:0] ADDR_FMT = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h01;
  localparam logic [7:0] ADDR_RXD = 8'h02;
  localparam logic [7:0] ADDR_TXD = 8'h03;
  localparam int BIT_ORDER = 3;
  localparam int BIT_FLIP = 2;
  localparam logic [3:0] RSVD_HI = 4'hf;
  localparam logic [1:0] RSVD_LO = 2'h0;
  localparam logic ORDER_RESET = 1'h0;
  localparam logic FLIP_RESET = 1'h0;
  localparam logic LINE_IDLE = 1'h1;
  localparam logic LINE_START = 1'h0;
  localparam logic [7:0] MASK7 = 8'h7f;
  localparam logic [7:0] MASK8 = 8'hff;
  localparam logic [3:0] LAST7 = 4'h6;
  localparam logic [3:0] LAST8 = 4'h7;
  localparam logic [3:0] CNT_STEP = 4'h1;
  localparam logic [3:0] STAT_PAD = 4'h0;

  typedef struct packed {
    logic char7;
    logic parity_en;
    logic parity_odd;
  } mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_PAR, RX_STOP} rx_state_t;

  typedef struct packed {
    logic order;
    logic flip;
    tx_state_t tx_state;
    logic [7:0] tx_shift;
    logic tx_par;
    logic [3:0] tx_cnt;
    logic tx_line;
    rx_state_t rx_state;
    logic [7:0] rx_v;
    logic [3:0] rx_cnt;
    logic rx_par;
    logic [7:0] rx_hold;
    logic rx_full;
    logic par_err;
    logic frm_err;
    logic sync1;
    logic sync2;
    logic [7:0] rdata;
  } state_t;

  function automatic logic [7:0] rev8(input logic [7:0] d);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < DATA_W; i++) begin
      r[i] = d[DATA_W - 1 - i];
    end
    return r;
  endfunction

  function automatic logic [7:0] len_mask(input logic char7);
    return char7 ? MASK7 : MASK8;
  endfunction

  function automatic logic [3:0] last_idx(input logic char7);
    return char7 ? LAST7 : LAST8;
  endfunction

  function automatic logic parity_of(input logic [7:0] d, input logic odd);
    return (^d) ^ odd;
  endfunction
endpackage

// >>> hdl/char_map.sv
/*
  Maps a character between holding-register order and line order.
  Assumes the same map serves both directions, since it is its own inverse.
*/
`timescale 1ns/1ps
`default_nettype none
module char_map (
  // Character in
  input wire logic [7:0] data,
  // Format settings
  input wire logic order,
  input wire logic flip,
  input wire logic char7,
  // Character out
  output logic [7:0] mapped
);
  logic [7:0] ordered;

  always_comb begin
    ordered = (order && !char7) ? serial_fmt_pkg::rev8(data) : data;
    mapped = (flip ? ~ordered : ordered) & serial_fmt_pkg::len_mask(char7);
  end
endmodule
`default_nettype wire

// >>> hdl/serial_format_ctl.sv
/*
  Serial format control: format register, transmit and receive shifters.
  Assumes bit_tick pulses once per bit time from a baud generator on clock,
  and mode comes from the serial mode register on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_format_ctl (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire serial_fmt_pkg::reg_req_t req,
  output logic [7:0] rdata,
  // Mode settings and bit timing
  input wire serial_fmt_pkg::mode_t mode,
  input wire logic bit_tick,
  // Serial line
  output logic tx_line,
  input wire logic rx_line
);
  serial_fmt_pkg::state_t s_reg;
  serial_fmt_pkg::state_t s_next;
  logic [7:0] tx_mapped;
  logic [7:0] rx_mapped;
  logic tx_load;
  logic [7:0] fmt_val;
  logic [7:0] stat_val;

  assign tx_load = req.wr && req.addr == serial_fmt_pkg::ADDR_TXD
    && s_reg.tx_state == serial_fmt_pkg::TX_IDLE;
  assign fmt_val = {serial_fmt_pkg::RSVD_HI, s_reg.order, s_reg.flip, serial_fmt_pkg::RSVD_LO};
  assign stat_val = {serial_fmt_pkg::STAT_PAD, s_reg.frm_err, s_reg.par_err, s_reg.rx_full,
    s_reg.tx_state != serial_fmt_pkg::TX_IDLE};

  char_map tx_map (
    .data(req.wdata),
    .order(s_reg.order),
    .flip(s_reg.flip),
    .char7(mode.char7),
    .mapped(tx_mapped)
  );

  char_map rx_map (
    .data(s_reg.rx_v),
    .order(s_reg.order),
    .flip(s_reg.flip),
    .char7(mode.char7),
    .mapped(rx_mapped)
  );

  always_comb begin
    s_next = s_reg;
    s_next.sync1 = rx_line;
    s_next.sync2 = s_reg.sync1;
    if (req.wr && req.addr == serial_fmt_pkg::ADDR_FMT) begin
      s_next.order = req.wdata[serial_fmt_pkg::BIT_ORDER];
      s_next.flip = req.wdata[serial_fmt_pkg::BIT_FLIP];
    end
    s_next.rdata = '0;
    if (req.rd) begin
      unique case (req.addr)
        serial_fmt_pkg::ADDR_FMT: s_next.rdata = fmt_val;
        serial_fmt_pkg::ADDR_STAT: s_next.rdata = stat_val;
        serial_fmt_pkg::ADDR_RXD: s_next.rdata = s_reg.rx_hold;
        default: s_next.rdata = '0;
      endcase
    end
    // Reading the data clears full; a completion below wins the same cycle
    if (req.rd && req.addr == serial_fmt_pkg::ADDR_RXD) begin
      s_next.rx_full = 1'b0;
    end
    // Writes while busy are dropped; software checks status first
    if (tx_load) begin
      s_next.tx_shift = tx_mapped;
      s_next.tx_par = serial_fmt_pkg::parity_of(
        req.wdata & serial_fmt_pkg::len_mask(mode.char7), mode.parity_odd);
      s_next.tx_cnt = '0;
      s_next.tx_state = serial_fmt_pkg::TX_START;
    end else if (bit_tick) begin
      unique case (s_reg.tx_state)
        serial_fmt_pkg::TX_IDLE: s_next.tx_line = serial_fmt_pkg::LINE_IDLE;
        serial_fmt_pkg::TX_START: begin
          s_next.tx_line = serial_fmt_pkg::LINE_START;
          s_next.tx_state = serial_fmt_pkg::TX_DATA;
        end
        serial_fmt_pkg::TX_DATA: begin
          s_next.tx_line = s_reg.tx_shift[0];
          s_next.tx_shift = s_reg.tx_shift >> 1;
          s_next.tx_cnt = s_reg.tx_cnt + serial_fmt_pkg::CNT_STEP;
          if (s_reg.tx_cnt == serial_fmt_pkg::last_idx(mode.char7)) begin
            s_next.tx_state = mode.parity_en ? serial_fmt_pkg::TX_PAR : serial_fmt_pkg::TX_STOP;
          end
        end
        serial_fmt_pkg::TX_PAR: begin
          s_next.tx_line = s_reg.tx_par;
          s_next.tx_state = serial_fmt_pkg::TX_STOP;
        end
        serial_fmt_pkg::TX_STOP: begin
          s_next.tx_line = serial_fmt_pkg::LINE_IDLE;
          s_next.tx_state = serial_fmt_pkg::TX_IDLE;
        end
      endcase
    end
    // Start is seen on one tick sample; no mid-bit search, timing is upstream
    if (bit_tick) begin
      unique case (s_reg.rx_state)
        serial_fmt_pkg::RX_IDLE: begin
          if (s_reg.sync2 == serial_fmt_pkg::LINE_START) begin
            s_next.rx_v = '0;
            s_next.rx_cnt = '0;
            s_next.rx_state = serial_fmt_pkg::RX_DATA;
          end
        end
        serial_fmt_pkg::RX_DATA: begin
          s_next.rx_v[s_reg.rx_cnt[2:0]] = s_reg.sync2;
          s_next.rx_cnt = s_reg.rx_cnt + serial_fmt_pkg::CNT_STEP;
          if (s_reg.rx_cnt == serial_fmt_pkg::last_idx(mode.char7)) begin
            s_next.rx_state = mode.parity_en ? serial_fmt_pkg::RX_PAR : serial_fmt_pkg::RX_STOP;
          end
        end
        serial_fmt_pkg::RX_PAR: begin
          s_next.rx_par = s_reg.sync2;
          s_next.rx_state = serial_fmt_pkg::RX_STOP;
        end
        serial_fmt_pkg::RX_STOP: begin
          s_next.rx_hold = rx_mapped;
          s_next.rx_full = 1'b1;
          s_next.frm_err = s_reg.sync2 != serial_fmt_pkg::LINE_IDLE;
          s_next.par_err = mode.parity_en
            && s_reg.rx_par != serial_fmt_pkg::parity_of(rx_mapped, mode.parity_odd);
          s_next.rx_state = serial_fmt_pkg::RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.order <= serial_fmt_pkg::ORDER_RESET;
      s_reg.flip <= serial_fmt_pkg::FLIP_RESET;
      s_reg.tx_line <= serial_fmt_pkg::LINE_IDLE;
      s_reg.sync1 <= serial_fmt_pkg::LINE_IDLE;
      s_reg.sync2 <= serial_fmt_pkg::LINE_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.rdata;
  assign tx_line = s_reg.tx_line;

  logic rx_done;
  assign rx_done = bit_tick && s_reg.rx_state == serial_fmt_pkg::RX_STOP;

  chk_fmt_bit_write: assert property (@(posedge clock) disable iff (!rst_n)
    req.wr && req.addr == serial_fmt_pkg::ADDR_FMT |=>
      s_reg.order == $past(req.wdata[serial_fmt_pkg::BIT_ORDER])
      && s_reg.flip == $past(req.wdata[serial_fmt_pkg::BIT_FLIP]))
    else $error("format bits not taken from write");
  chk_fmt_read_back: assert property (@(posedge clock) disable iff (!rst_n)
    req.rd && req.addr == serial_fmt_pkg::ADDR_FMT |=>
      rdata == {serial_fmt_pkg::RSVD_HI, $past(s_reg.order), $past(s_reg.flip),
        serial_fmt_pkg::RSVD_LO})
    else $error("format readback wrong");
  chk_tx_lsb_plain: assert property (@(posedge clock) disable iff (!rst_n)
    tx_load && !s_reg.order && !s_reg.flip && !mode.char7 |=>
      s_reg.tx_shift == $past(req.wdata))
    else $error("lsb first transmit image wrong");
  chk_tx_msb_order: assert property (@(posedge clock) disable iff (!rst_n)
    tx_load && s_reg.order && !s_reg.flip && !mode.char7 |=>
      s_reg.tx_shift == serial_fmt_pkg::rev8($past(req.wdata)))
    else $error("msb first transmit image wrong");
  chk_tx_seven_lsb: assert property (@(posedge clock) disable iff (!rst_n)
    tx_load && s_reg.order && !s_reg.flip && mode.char7 |=>
      s_reg.tx_shift == ($past(req.wdata) & serial_fmt_pkg::MASK7))
    else $error("7-bit transmit not lsb first");
  chk_tx_flip_data: assert property (@(posedge clock) disable iff (!rst_n)
    tx_load && !s_reg.order && s_reg.flip && !mode.char7 |=>
      s_reg.tx_shift == ~$past(req.wdata))
    else $error("transmit data not inverted");
  chk_tx_parity_level: assert property (@(posedge clock) disable iff (!rst_n)
    tx_load && !mode.char7 |=> s_reg.tx_par == ((^$past(req.wdata)) ^ $past(mode.parity_odd)))
    else $error("parity follows inversion");
  chk_rx_plain_store: assert property (@(posedge clock) disable iff (!rst_n)
    rx_done && !s_reg.order && !s_reg.flip && !mode.char7 |=>
      s_reg.rx_hold == $past(s_reg.rx_v) && s_reg.rx_full)
    else $error("receive data modified");
  chk_rx_msb_store: assert property (@(posedge clock) disable iff (!rst_n)
    rx_done && s_reg.order && !s_reg.flip && !mode.char7 |=>
      s_reg.rx_hold == serial_fmt_pkg::rev8($past(s_reg.rx_v)))
    else $error("msb first receive store wrong");
  chk_rx_flip_store: assert property (@(posedge clock) disable iff (!rst_n)
    rx_done && !s_reg.order && s_reg.flip && !mode.char7 |=>
      s_reg.rx_hold == ~$past(s_reg.rx_v))
    else $error("receive data not inverted");
  chk_tx_msb_flip: assert property (@(posedge clock) disable iff (!rst_n)
    tx_load && s_reg.order && s_reg.flip && !mode.char7 |=>
      s_reg.tx_shift == ~serial_fmt_pkg::rev8($past(req.wdata)))
    else $error("msb first inverted transmit image wrong");
  // Parity goes to the line from its own register, never through the data map
  chk_tx_parity_bit: assert property (@(posedge clock) disable iff (!rst_n)
    bit_tick && s_reg.tx_state == serial_fmt_pkg::TX_PAR |=>
      tx_line == $past(s_reg.tx_par))
    else $error("parity bit level changed on the line");
  chk_rx_seven_store: assert property (@(posedge clock) disable iff (!rst_n)
    rx_done && s_reg.order && !s_reg.flip && mode.char7 |=>
      s_reg.rx_hold == ($past(s_reg.rx_v) & serial_fmt_pkg::MASK7))
    else $error("7-bit receive not lsb first");
  chk_rx_msb_flip: assert property (@(posedge clock) disable iff (!rst_n)
    rx_done && s_reg.order && s_reg.flip && !mode.char7 |=>
      s_reg.rx_hold == ~serial_fmt_pkg::rev8($past(s_reg.rx_v)))
    else $error("msb first inverted receive store wrong");
  chk_rx_parity_check: assert property (@(posedge clock) disable iff (!rst_n)
    rx_done && mode.parity_en |=>
      s_reg.par_err == ($past(s_reg.rx_par) != ((^s_reg.rx_hold) ^ $past(mode.parity_odd))))
    else $error("receive parity not checked at normal level");
endmodule
`default_nettype wire

// >>> bench/remote_serial.sv
/*
  Remote serial device: captures frames from tx_line, sends frames on rx_line.
  Assumes bit_tick marks mid-bit and the line idles high between frames.
*/
`timescale 1ns/1ps
`default_nettype none
module remote_serial (
  // Timing
  input wire logic clock,
  input wire logic bit_tick,
  // Line
  input wire logic tx_line,
  output logic rx_line,
  // Capture
  input wire logic [3:0] nbits,
  output logic [10:0] cap,
  output logic cap_done
);
  int n;
  initial begin
    rx_line = 1'b1;
    cap = '0;
    cap_done = 1'b0;
    n = -1;
  end
  // Start bit seen on a tick, then nbits elements in line order
  always @(posedge clock) begin
    cap_done <= 1'b0;
    if (bit_tick && n < 0 && tx_line === 1'b0) begin
      cap <= '0;
      n = 0;
    end else if (bit_tick && n >= 0) begin
      cap[n] <= tx_line;
      n = n + 1;
      if (n == int'(nbits)) begin
        cap_done <= 1'b1;
        n = -1;
      end
    end
  end
  // Aligned to a tick so the two-flop sync settles before the next one;
  // the line returns to idle so a bad stop bit is not taken as a new start
  task automatic send(input logic [10:0] b, input int cnt);
    @(posedge clock iff bit_tick);
    rx_line <= 1'b0;
    @(posedge clock iff bit_tick);
    for (int i = 0; i < cnt; i++) begin
      rx_line <= b[i];
      @(posedge clock iff bit_tick);
    end
    rx_line <= 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> bench/tb.sv
/*
  Testbench for serial_format_ctl: register port, transmit and receive frames.
  Assumes bit_tick from a divide-by-4 counter here and remote_serial on the line.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic bit_tick = 1'b0;
  logic [1:0] tcnt = 2'h0;
  logic [7:0] rdata, got, v;
  logic tx_line, rx_line, ord, flp, c7, pe, po, bad, cap_done;
  logic [3:0] nb = 4'ha;
  logic [10:0] f, cap;
  int n, miscompares = 0, compares = 0, cycles = 0;
  serial_fmt_pkg::reg_req_t req = '0;
  serial_fmt_pkg::mode_t mode = '0;

  serial_format_ctl serial_format_ctl_i (.clock(clock), .rst_n(rst_n), .req(req),
    .rdata(rdata), .mode(mode), .bit_tick(bit_tick), .tx_line(tx_line), .rx_line(rx_line));
  remote_serial remote_serial_i (.clock(clock), .bit_tick(bit_tick), .tx_line(tx_line),
    .rx_line(rx_line), .nbits(nb), .cap(cap), .cap_done(cap_done));

  always #50 clock = ~clock;
  always @(posedge clock) begin
    tcnt <= tcnt + 2'h1;
    bit_tick <= (tcnt == 2'h3);
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  task automatic results();
    if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [10:0] g, input logic [10:0] e, input string what);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clock);
    req.wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clock);
    req.rd <= 1'b0;
    @(posedge clock);
    d = rdata;
  endtask
  // Line order of data, then raw parity, then stop
  function automatic logic [10:0] frame(input logic [7:0] d, input logic o, input logic fl,
      input logic s7, input logic p, input logic odd, output int cnt);
    logic [10:0] r;
    r = '0;
    cnt = s7 ? 7 : 8;
    for (int i = 0; i < cnt; i++) r[i] = ((o && !s7) ? d[7 - i] : d[i]) ^ fl;
    if (p) begin
      r[cnt] = (^(d & (s7 ? 8'h7f : 8'hff))) ^ odd;
      cnt++;
    end
    r[cnt] = 1'b1;
    cnt++;
    return r;
  endfunction

  initial begin
    void'($urandom(54175));
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd_reg(serial_fmt_pkg::ADDR_FMT, got);
    check(11'(got), 11'h0f0, "format reset");
    wr_reg(8'h04, 8'hff);
    rd_reg(8'h04, got);
    check(11'(got), 11'h000, "unmapped read");
    for (int i = 0; i < 24; i++) begin
      {bad, po, pe, c7, flp, ord} = (i < 8) ? 6'(i) : 6'($urandom);
      v = (i < 8) ? 8'h81 : 8'($urandom);
      wr_reg(serial_fmt_pkg::ADDR_FMT, {4'h0, ord, flp, 2'h0});
      rd_reg(serial_fmt_pkg::ADDR_FMT, got);
      check(11'(got), {3'h0, 4'hf, ord, flp, 2'h0}, "format read");
      // parity sense is only ever set through the odd/even choice
      mode <= '{char7: c7, parity_en: pe, parity_odd: po};
      f = frame(v, ord, flp, c7, pe, po, n);
      nb <= 4'(n);
      wr_reg(serial_fmt_pkg::ADDR_TXD, v);
      wr_reg(serial_fmt_pkg::ADDR_TXD, ~v);
      rd_reg(serial_fmt_pkg::ADDR_STAT, got);
      check(11'(got[0]), 11'h001, "transmit busy");
      for (int k = 0; k < 400; k++) begin
        @(posedge clock);
        if (cap_done === 1'b1) break;
      end
      check(cap, f, "transmit frame");
      v = 8'($urandom);
      f = frame(v, ord, flp, c7, pe, po, n);
      // Corrupt parity when enabled, otherwise the stop bit
      if (bad) f[n - (pe ? 2 : 1)] = ~f[n - (pe ? 2 : 1)];
      remote_serial_i.send(f, n);
      rd_reg(serial_fmt_pkg::ADDR_STAT, got);
      check(11'(got[3:0]), {7'h00, bad & ~pe, pe & bad, 1'b1, 1'b0}, "receive status");
      rd_reg(serial_fmt_pkg::ADDR_RXD, got);
      check(11'(got), 11'(c7 ? {1'b0, v[6:0]} : v), "receive data");
      rd_reg(serial_fmt_pkg::ADDR_STAT, got);
      check(11'(got[1]), 11'h000, "full after data read");
    end
    results();
  end
endmodule
`default_nettype wire
